//--- rtl/ssra_top.sv
// serial slave port giving an external host word access to the core register bus
`timescale 1ns/100ps

module ssra_top (
   input  wire logic                clk_sys_i,
   input  wire logic                rst_i,
   input  wire logic                serial_clk_i,
   input  wire logic                slave_select_n_i,
   input  wire logic                serial_data_in_i,
   output logic                     serial_data_out_o,
   output logic                     serial_data_out_oe_n_o,
   input  wire logic [1:0]          owner_sel_i,
   input  wire logic                cpu_req_i,
   input  wire ssra_pkg::ssra_req_t cpu_cmd_i,
   output ssra_pkg::ssra_rsp_t      cpu_rsp_o,
   output logic                     core_req_o,
   output ssra_pkg::ssra_req_t      core_cmd_o,
   input  wire logic                core_ack_i,
   input  wire logic [31:0]         core_rdata_i,
   output logic [1:0]               if_ctrl_o,
   output logic [1:0]               pad_cnt_o,
   output logic                     pad_err_o,
   output logic                     bus_timeout_o
);
   import ssra_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // link-side declarations
   logic [6:0]  cnt_ff;
   logic        rw_ff;
   logic [21:0] addr_ff;
   logic [31:0] data_sr_ff;
   logic        loc_hit_ff;
   logic [31:0] loc_rd_ff;
   logic [1:0]  if_ctrl_ff;
   logic [1:0]  pad_ff;
   logic        clr_tgl_ff;
   logic        req_tgl_ff;
   ssra_req_t   req_ff;
   logic [31:0] tx_sr_ff;
   logic        sdo_ff;
   logic        oe_n_ff;
   logic        err_ff;
   logic        clr_seen_ff;
   logic        done_sync_w;

   // system-side declarations
   logic        owner_ff;
   logic        seen_ff;
   logic        pend_ff;
   logic        done_tgl_ff;
   logic [31:0] rd_word_ff;
   logic        timeout_ff;
   logic        req_sync_w;
   ssra_rsp_t   ser_rsp_w;

   ////////////////////////////////////////////////////////////////////////////////
   // frame decode
   // deselect or lost ownership aborts the frame at once, even with the clock stopped
   wire frame_rst_w = rst_i | slave_select_n_i | ~owner_ff;

   wire [21:0] nxt_addr_w   = {addr_ff[20:0], serial_data_in_i};
   wire [31:0] nxt_data_w   = {data_sr_ff[30:0], serial_data_in_i};
   wire        swap_w       = if_ctrl_ff[IFCTRL_SWAP_BIT];
   wire        lsbf_w       = if_ctrl_ff[IFCTRL_LSBF_BIT];
   wire [31:0] wr_word_w    = ssra_order(nxt_data_w, swap_w, lsbf_w);
   wire        addr_done_w  = (cnt_ff == 7'(HDR_BITS - 1));
   wire        wr_done_w    = ~rw_ff && (cnt_ff == 7'(HDR_BITS + DATA_BITS - 1));
   wire        hit_ctrl_w   = (nxt_addr_w == IFCTRL_WADDR);
   wire        hit_cfg_w    = (nxt_addr_w == CFGSTAT_WADDR);
   wire        err_vis_w    = err_ff & (clr_tgl_ff == clr_seen_ff);
   wire [31:0] ctrl_word_w  = 32'(if_ctrl_ff);
   wire [31:0] cfg_word_w   = (32'(pad_ff) << CFG_PAD_LSB) | (32'(err_vis_w) << CFG_STAT_BIT);

   // read data timing
   wire [6:0]  data_start_w = 7'(HDR_BITS) + 7'({pad_ff, 3'h0});
   wire [6:0]  data_last_w  = data_start_w + 7'(DATA_BITS - 1);
   wire        first_w      = rw_ff && (cnt_ff == data_start_w);
   wire        drive_w      = rw_ff && (cnt_ff > data_start_w) && (cnt_ff <= data_last_w);
   wire        rd_rdy_w     = (done_sync_w == req_tgl_ff);
   wire        underrun_w   = first_w && ~loc_hit_ff && (pad_ff != 2'h0) && ~rd_rdy_w;
   // remote data is quasi-static here: the host has waited the access time
   wire [31:0] tx_word_w    = loc_hit_ff ? loc_rd_ff :
                              underrun_w ? PAD_ERR_WORD : rd_word_ff;
   wire [31:0] tx_ord_w     = ssra_order(tx_word_w, swap_w, lsbf_w);

   ////////////////////////////////////////////////////////////////////////////////
   // receive shifter, cleared with every frame
   always_ff @(posedge serial_clk_i or posedge frame_rst_w) begin
      if (frame_rst_w) begin
         cnt_ff     <= 7'h00;
         rw_ff      <= 1'b0;
         addr_ff    <= 22'h00_0000;
         data_sr_ff <= 32'h0000_0000;
         loc_hit_ff <= 1'b0;
         loc_rd_ff  <= 32'h0000_0000;
      end else begin
         if (cnt_ff != 7'h7f) begin
            cnt_ff <= cnt_ff + 7'h01;
         end
         if (cnt_ff == 7'(RW_SLOT)) begin
            rw_ff <= serial_data_in_i;
         end
         if ((cnt_ff >= 7'(ADDR_SLOT)) && (cnt_ff < 7'(HDR_BITS))) begin
            addr_ff <= nxt_addr_w;
         end
         if (cnt_ff >= 7'(HDR_BITS)) begin
            data_sr_ff <= nxt_data_w;
         end
         if (addr_done_w) begin
            loc_hit_ff <= hit_ctrl_w | hit_cfg_w;
            loc_rd_ff  <= hit_ctrl_w ? ctrl_word_w : cfg_word_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // link-side registers and requests, kept across frames
   always_ff @(posedge serial_clk_i or posedge rst_i) begin
      if (rst_i) begin
         if_ctrl_ff <= IFCTRL_RST;
         pad_ff     <= PAD_RST;
         clr_tgl_ff <= 1'b0;
         req_tgl_ff <= 1'b0;
         req_ff     <= '0;
      end else begin
         if (addr_done_w && rw_ff && ~(hit_ctrl_w | hit_cfg_w)) begin
            req_ff     <= '{we: 1'b0, addr: nxt_addr_w, wdata: 32'h0000_0000};
            req_tgl_ff <= ~req_tgl_ff;
         end else if (wr_done_w) begin
            if (addr_ff == IFCTRL_WADDR) begin
               if_ctrl_ff <= wr_word_w[1:0];
            end else if (addr_ff == CFGSTAT_WADDR) begin
               pad_ff <= wr_word_w[CFG_PAD_LSB +: PAD_W];
               if (wr_word_w[CFG_STAT_BIT]) begin
                  clr_tgl_ff <= ~clr_tgl_ff;
               end
            end else begin
               req_ff     <= '{we: 1'b1, addr: addr_ff, wdata: wr_word_w};
               req_tgl_ff <= ~req_tgl_ff;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmit side, updated on the falling edge
   always_ff @(negedge serial_clk_i or posedge frame_rst_w) begin
      if (frame_rst_w) begin
         tx_sr_ff <= 32'h0000_0000;
         sdo_ff   <= 1'b0;
         oe_n_ff  <= 1'b1;
      end else begin
         if (first_w) begin
            tx_sr_ff <= {tx_ord_w[30:0], 1'b0};
            sdo_ff   <= tx_ord_w[31];
            oe_n_ff  <= 1'b0;
         end else if (drive_w) begin
            tx_sr_ff <= {tx_sr_ff[30:0], 1'b0};
            sdo_ff   <= tx_sr_ff[31];
         end else begin
            oe_n_ff  <= 1'b1;
         end
      end
   end

   // sticky underrun flag; a new underrun wins over a pending clear
   always_ff @(negedge serial_clk_i or posedge rst_i) begin
      if (rst_i) begin
         err_ff      <= 1'b0;
         clr_seen_ff <= 1'b0;
      end else begin
         clr_seen_ff <= clr_tgl_ff;
         if (underrun_w) begin
            err_ff <= 1'b1;
         end else if (clr_tgl_ff != clr_seen_ff) begin
            err_ff <= 1'b0;
         end
      end
   end

   ssra_sync3 u_done_sync (
      .clk_i (serial_clk_i),
      .rst_i (rst_i),
      .d_i   (done_tgl_ff),
      .q_o   (done_sync_w)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // system side: request pickup and answer return
   ssra_sync3 u_req_sync (
      .clk_i (clk_sys_i),
      .rst_i (rst_i),
      .d_i   (req_tgl_ff),
      .q_o   (req_sync_w)
   );

   wire new_req_w = (req_sync_w != seen_ff);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         owner_ff    <= 1'b0;
         seen_ff     <= 1'b0;
         pend_ff     <= 1'b0;
         done_tgl_ff <= 1'b0;
         rd_word_ff  <= 32'h0000_0000;
         timeout_ff  <= 1'b0;
      end else begin
         owner_ff   <= (owner_sel_i == OWNER_SLAVE);
         seen_ff    <= req_sync_w;
         timeout_ff <= (ser_rsp_w.ack & ser_rsp_w.timeout) | (cpu_rsp_o.ack & cpu_rsp_o.timeout);
         if (new_req_w) begin
            pend_ff <= 1'b1;
         end else if (ser_rsp_w.ack) begin
            pend_ff <= 1'b0;
         end
         if (ser_rsp_w.ack) begin
            rd_word_ff  <= ser_rsp_w.rdata;
            done_tgl_ff <= ~done_tgl_ff;
         end
      end
   end

   ssra_arb u_arb (
      .clk_i        (clk_sys_i),
      .rst_i        (rst_i),
      .m0_req_i     (pend_ff),
      .m0_cmd_i     (req_ff),
      .m0_rsp_o     (ser_rsp_w),
      .m1_req_i     (cpu_req_i),
      .m1_cmd_i     (cpu_cmd_i),
      .m1_rsp_o     (cpu_rsp_o),
      .core_req_o   (core_req_o),
      .core_cmd_o   (core_cmd_o),
      .core_ack_i   (core_ack_i),
      .core_rdata_i (core_rdata_i)
   );

   assign serial_data_out_o      = sdo_ff;
   assign serial_data_out_oe_n_o = oe_n_ff;
   assign if_ctrl_o              = if_ctrl_ff;
   assign pad_cnt_o              = pad_ff;
   assign pad_err_o              = err_ff;
   assign bus_timeout_o          = timeout_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_addr_read;
      addr_done_w && rw_ff && !(hit_ctrl_w | hit_cfg_w);
   endsequence

   AST_OE_READ_ONLY: assert property (@(posedge serial_clk_i) disable iff (frame_rst_w)
      !oe_n_ff |-> rw_ff && cnt_ff >= data_start_w && cnt_ff <= data_last_w)
      else $error("data out driven outside read data");
   AST_PAD_RELEASED: assert property (@(posedge serial_clk_i) disable iff (frame_rst_w)
      cnt_ff < data_start_w |-> oe_n_ff)
      else $error("data out driven during header or padding");
   AST_READ_FETCH: assert property (@(posedge serial_clk_i) disable iff (frame_rst_w)
      s_addr_read |=> req_tgl_ff != $past(req_tgl_ff) && !req_ff.we)
      else $error("read fetch not issued at last address bit");
   AST_UNDERRUN_FLAG: assert property (@(negedge serial_clk_i) disable iff (rst_i)
      underrun_w |=> err_ff)
      else $error("underrun did not set the error flag");
   AST_CTRL_WRITE: assert property (@(posedge serial_clk_i) disable iff (frame_rst_w)
      wr_done_w && addr_ff == IFCTRL_WADDR |=> if_ctrl_ff == $past(wr_word_w[1:0]))
      else $error("order control write not taken");
   AST_FIRST_BIT: assert property (@(negedge serial_clk_i) disable iff (frame_rst_w)
      first_w |=> sdo_ff == $past(tx_ord_w[31]) && !oe_n_ff)
      else $error("first read bit not the ordered msb");
endmodule // ssra_top

//--- rtl/ssra_pkg.sv
// shared constants, carriers and helpers for the serial slave register access block
package ssra_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clocking and access times
   localparam int CLK_SYS_MHZ  = 200;
   localparam int FAST_ACC_NS  = 100;
   localparam int NORM_ACC_NS  = 1000;
   // longest times round down to whole cycles
   localparam int FAST_ACC_CYC = FAST_ACC_NS * CLK_SYS_MHZ / 1000;
   localparam int NORM_ACC_CYC = NORM_ACC_NS * CLK_SYS_MHZ / 1000;

   ////////////////////////////////////////////////////////////////////////////////
   // frame layout
   localparam int ADDR_BITS    = 22;
   localparam int HDR_BITS     = 24;
   localparam int DATA_BITS    = 32;
   localparam int RW_SLOT      = 0;
   localparam int ADDR_SLOT    = 2;
   localparam logic [31:0] PAD_ERR_WORD = 32'h8888_8888;

   ////////////////////////////////////////////////////////////////////////////////
   // local registers reached over the serial link
   localparam logic [21:0] IFCTRL_WADDR  = 22'h3f_fff0;
   localparam logic [21:0] CFGSTAT_WADDR = 22'h3f_fff1;
   localparam int          IFCTRL_SWAP_BIT = 0;
   localparam int          IFCTRL_LSBF_BIT = 1;
   localparam logic [1:0]  IFCTRL_RST      = 2'h0;
   localparam int          PAD_W           = 2;
   localparam int          CFG_PAD_LSB     = 0;
   localparam int          CFG_STAT_BIT    = 16;
   localparam logic [1:0]  PAD_RST         = 2'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // pin ownership and fast targets
   localparam logic [1:0]  OWNER_SLAVE = 2'h2;
   localparam int          TGT_LSB     = 16;
   localparam logic [5:0]  FAST_TGT_A  = 6'h3e;
   localparam logic [5:0]  FAST_TGT_B  = 6'h3d;

   typedef struct packed {
      logic        we;
      logic [21:0] addr;
      logic [31:0] wdata;
   } ssra_req_t;

   typedef struct packed {
      logic        ack;
      logic        timeout;
      logic [31:0] rdata;
   } ssra_rsp_t;

   // byte swap and per-byte bit reversal; both are involutions, so one
   // function serves receive and transmit alike
   function automatic logic [31:0] ssra_order(input logic [31:0] w, input logic swap,
                                              input logic lsbf);
      logic [31:0] b;
      b = swap ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
      ssra_order = b;
      if (lsbf) begin
         for (int i = 0; i < 32; i++) begin
            ssra_order[i] = b[(i & ~7) + 7 - (i & 7)];
         end
      end
   endfunction

   function automatic logic ssra_is_fast(input logic [21:0] addr);
      ssra_is_fast = (addr[TGT_LSB +: 6] == FAST_TGT_A) || (addr[TGT_LSB +: 6] == FAST_TGT_B);
   endfunction

endpackage

//--- rtl/ssra_sync3.sv
// three-stage level synchroniser that passes a change once stages two and three agree
`timescale 1ns/100ps
module ssra_sync3 (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic q_ff;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         q_ff  <= 1'b0;
      end else begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            q_ff <= s3_ff;
         end
      end
   end

   assign q_o = q_ff;
endmodule // ssra_sync3

//--- rtl/ssra_arb.sv
// round-robin arbiter of two masters onto the core register bus, with access-time limit
`timescale 1ns/100ps
module ssra_arb (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              m0_req_i,
   input  wire ssra_pkg::ssra_req_t m0_cmd_i,
   output ssra_pkg::ssra_rsp_t    m0_rsp_o,
   input  wire logic              m1_req_i,
   input  wire ssra_pkg::ssra_req_t m1_cmd_i,
   output ssra_pkg::ssra_rsp_t    m1_rsp_o,
   output logic                   core_req_o,
   output ssra_pkg::ssra_req_t    core_cmd_o,
   input  wire logic              core_ack_i,
   input  wire logic [31:0]       core_rdata_i
);
   import ssra_pkg::*;

   typedef enum {ARB_IDLE, ARB_BUSY, ARB_DONE} ssra_arb_st_t;

   localparam int AST_FAST_MAX = FAST_ACC_CYC;
   localparam int AST_NORM_MAX = NORM_ACC_CYC;

   ssra_arb_st_t st_ff;
   logic         rr_ff;
   logic         own_ff;
   logic [7:0]   cnt_ff;
   logic [7:0]   lim_ff;
   logic         req_ff;
   ssra_req_t    cmd_ff;
   ssra_rsp_t    rsp0_ff;
   ssra_rsp_t    rsp1_ff;

   wire fast0_w  = ssra_is_fast(m0_cmd_i.addr);
   wire fast1_w  = ssra_is_fast(m1_cmd_i.addr);
   // fast targets bypass the turn order
   wire pick1_w  = m1_req_i & (~m0_req_i | (fast1_w & ~fast0_w) |
                               (~(fast0_w & ~fast1_w) & rr_ff));
   wire ssra_req_t pick_cmd_w = pick1_w ? m1_cmd_i : m0_cmd_i;
   wire finish_w = core_ack_i | (cnt_ff == lim_ff - 8'h01);
   wire ssra_rsp_t fin_rsp_w = '{ack: 1'b1, timeout: ~core_ack_i,
                                rdata: core_ack_i ? core_rdata_i : PAD_ERR_WORD};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff   <= ARB_IDLE;
         rr_ff   <= 1'b0;
         own_ff  <= 1'b0;
         cnt_ff  <= 8'h00;
         lim_ff  <= 8'h00;
         req_ff  <= 1'b0;
         cmd_ff  <= '0;
         rsp0_ff <= '0;
         rsp1_ff <= '0;
      end else begin
         rsp0_ff.ack <= 1'b0;
         rsp1_ff.ack <= 1'b0;
         unique case (st_ff)
            ARB_IDLE: begin
               if (m0_req_i | m1_req_i) begin
                  own_ff <= pick1_w;
                  cmd_ff <= pick_cmd_w;
                  req_ff <= 1'b1;
                  cnt_ff <= 8'h00;
                  lim_ff <= ssra_is_fast(pick_cmd_w.addr) ? 8'(FAST_ACC_CYC)
                                                          : 8'(NORM_ACC_CYC);
                  st_ff  <= ARB_BUSY;
               end
            end
            ARB_BUSY: begin
               cnt_ff <= cnt_ff + 8'h01;
               if (finish_w) begin
                  req_ff <= 1'b0;
                  rr_ff  <= ~own_ff;
                  if (own_ff) begin
                     rsp1_ff <= fin_rsp_w;
                  end else begin
                     rsp0_ff <= fin_rsp_w;
                  end
                  st_ff <= ARB_DONE;
               end
            end
            ARB_DONE: begin
               st_ff <= ARB_IDLE;
            end
         endcase
      end
   end

   assign core_req_o = req_ff;
   assign core_cmd_o = cmd_ff;
   assign m0_rsp_o   = rsp0_ff;
   assign m1_rsp_o   = rsp1_ff;

   ////////////////////////////////////////////////////////////////////////////////
   AST_NORM_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(core_req_o) |-> ##[1:AST_NORM_MAX] !core_req_o)
      else $error("core access outlived the normal access time");
   AST_FAST_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(core_req_o) && ssra_is_fast(core_cmd_o.addr) |-> ##[1:AST_FAST_MAX] !core_req_o)
      else $error("fast access outlived the fast access time");
   AST_RR_TURN: assert property (@(posedge clk_i) disable iff (rst_i)
      m0_rsp_o.ack && m1_req_i && m0_req_i && !fast0_w && !fast1_w
      |-> ##2 (core_req_o && own_ff))
      else $error("waiting master was not served next");
   AST_TIMEOUT_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
      m0_rsp_o.ack && m0_rsp_o.timeout |-> m0_rsp_o.rdata == PAD_ERR_WORD ##1 !m0_rsp_o.ack)
      else $error("timed-out access returned wrong data or long ack");
endmodule // ssra_arb

//--- verification/ssra_host.sv
// host model: drives frames on the serial link, clock idle low between frames
`timescale 1ns/100ps
module ssra_host (
   output logic      sclk_o,
   output logic      sel_n_o,
   output logic      mosi_o,
   input  wire logic miso_i,
   input  wire logic oe_n_i
);
   initial begin
      sclk_o = 1'b0;
      sel_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // nb bits of frame f; gap holds the clock high after the last address bit
   task automatic xfer(input logic [55:0] f, input int pad, input int gap, input int nb,
                       output logic [31:0] q, output logic ok);
      int d;
      ok = 1'b1;
      sel_n_o = 1'b0;
      for (int i = 0; i < nb; i++) begin
         d = i - 24 - 8 * pad;
         mosi_o = (i < 24) ? f[55-i] : (d >= 0) ? f[31-d] : ~mosi_o;
         #40 sclk_o = 1'b1;
         if (oe_n_i !== (!f[55] || d < 0)) ok = 1'b0;
         if (d >= 0) q = {q[30:0], miso_i};
         // a long high phase here also stands in for a slow clock
         if (i == 23) #(gap);
         #40 sclk_o = 1'b0;
      end
      #40 sel_n_o = 1'b1;
      // released line shows the inverse, not the last value
      mosi_o = ~mosi_o;
   endtask
endmodule // ssra_host

//--- verification/test_serial_slave_register_access.sv
// self-checking bench: serial frames, core bus target and second master
`timescale 1ns/100ps
module test_serial_slave_register_access;
   import ssra_pkg::*;
   logic        clk_sys_i, rst_i, sclk, sel_n, mosi, miso, oe_n, cpu_req, core_req, core_ack;
   logic        pad_err, tmo, ok;
   logic [1:0]  owner, ifc, padc, cf;
   logic [21:0] a;
   logic [31:0] core_rdata, q, w;
   ssra_req_t   cpu_cmd, core_cmd, last;
   ssra_rsp_t   cpu_rsp;
   int          n_mismatch, checked, dly, nwr, cnt, n0;

   ssra_top i_ssra_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .serial_clk_i(sclk),
      .slave_select_n_i(sel_n), .serial_data_in_i(mosi), .serial_data_out_o(miso),
      .serial_data_out_oe_n_o(oe_n), .owner_sel_i(owner), .cpu_req_i(cpu_req),
      .cpu_cmd_i(cpu_cmd), .cpu_rsp_o(cpu_rsp), .core_req_o(core_req),
      .core_cmd_o(core_cmd), .core_ack_i(core_ack), .core_rdata_i(core_rdata),
      .if_ctrl_o(ifc), .pad_cnt_o(padc), .pad_err_o(pad_err), .bus_timeout_o(tmo));
   ssra_host i_ssra_host (.sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi), .miso_i(miso),
      .oe_n_i(oe_n));

   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // core target: answers after dly cycles, reads return the last written word
   always @(posedge clk_sys_i) begin
      core_ack <= 1'b0;
      cnt <= (core_req && !core_ack) ? cnt + 1 : 0;
      if (core_req && !core_ack && cnt == dly) begin
         core_ack <= 1'b1;
         core_rdata <= last.wdata;
         if (core_cmd.we) begin
            last <= core_cmd;
            nwr <= nwr + 1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] mapw(input logic [31:0] v, input logic [1:0] c);
      logic [31:0] b;
      b = c[0] ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
      mapw = b;
      if (c[1]) for (int i = 0; i < 32; i++) mapw[i] = b[(i / 8) * 8 + 7 - i % 8];
   endfunction
   task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [21:0] ad, input logic [31:0] v, input int nb = 56);
      i_ssra_host.xfer({2'b00, ad, mapw(v, cf)}, 0, 0, nb, q, ok);
      #2000;
   endtask
   task automatic rd(input logic [21:0] ad, input int pad, input int gap);
      i_ssra_host.xfer({2'b10, ad, 32'h0}, pad, gap, 56 + 8 * pad, q, ok);
      #2000; // budget for targets shared with a second master
   endtask
   // pattern reads the same under every ordering
   task automatic setc(input logic [1:0] c);
      wr(IFCTRL_WADDR, {4{c[0], c[1], 4'h0, c[1], c[0]}});
      cf = c;
      chk("if_ctrl", c, ifc);
   endtask
   task automatic cpu(input logic [21:0] ad, input int lim);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      #1;
      cpu_cmd = '{1'b0, ad, 32'h0};
      cpu_req = 1'b1;
      while (cpu_rsp.ack !== 1'b1 && n < 400) begin
         @(posedge clk_sys_i);
         #1 n++;
      end
      chk("timeout", {1'b1, PAD_ERR_WORD}, {cpu_rsp.timeout, cpu_rsp.rdata});
      chk("limit", 1, n >= lim && n <= lim + 6);
      @(posedge clk_sys_i);
      #1 cpu_req = 1'b0;
      repeat (4) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #400000;
      n_mismatch++;
      report_and_stop;
   end

   initial begin
      rst_i = 1'b1;
      owner = OWNER_SLAVE;
      {cpu_req, cpu_cmd, core_ack, core_rdata, last} = '0;
      {dly, cf, n_mismatch, checked, nwr, cnt} = '0;
      repeat (10) @(posedge clk_sys_i);
      #1 rst_i = 1'b0;
      repeat (3) @(posedge clk_sys_i);
      dly = 4;
      for (int k = 0; k < 4; k++) begin
         setc(k[1:0]);
         a = 22'(((32'hc104_8d14 + 4 * k) & 32'h00ff_ffff) >> 2);
         w = 32'h1234_5678 ^ (32'h0f01_8003 << k);
         wr(a, w);
         chk("core write", {1'b1, a, w}, last);
         rd(a, 0, 1500);
         chk("read", mapw(w, cf), q);
         chk("oe", 1, ok);
      end
      setc(2'b00);
      wr(CFGSTAT_WADDR, 32'h1);
      chk("pad", 1, padc);
      dly = 20;
      rd(a, 1, 0);
      chk("pad read", w, q);
      chk("pad oe", 1, ok);
      dly = 150;
      rd(a, 1, 0);
      chk("underrun", PAD_ERR_WORD, q);
      chk("err", 1, pad_err);
      dly = 4;
      wr(CFGSTAT_WADDR, 32'h0001_0000);
      chk("err clear", 0, pad_err);
      n0 = nwr;
      wr(a, 32'hdead_beef, 30);
      wr(a, 32'h0bad_f00d);
      chk("abort", {n0 + 1, 32'h0bad_f00d}, {nwr, last.wdata});
      @(posedge clk_sys_i);
      #1 owner = 2'h0;
      wr(a, 32'h1111_1111);
      chk("foreign", {n0 + 1, 1'b1}, {nwr, ok});
      owner = OWNER_SLAVE;
      dly = 300;
      cpu(a, 200);
      cpu({FAST_TGT_A, 16'h0040}, 20);
      report_and_stop;
   end
endmodule // test_serial_slave_register_access
